// ==== include/hsq_pkg.sv ====
/*
 * Homing sequencer definitions: map, fields, modes, codes, states, carriers.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package hsq_pkg;

    // register byte offsets
    localparam logic [5:0] HSQ_OFS_CTRL = 6'h00;
    localparam logic [5:0] HSQ_OFS_STATUS = 6'h04;
    localparam logic [5:0] HSQ_OFS_HOME_OFFSET = 6'h08;
    localparam logic [5:0] HSQ_OFS_MECH_HOME = 6'h0c;
    localparam logic [5:0] HSQ_OFS_SOFT_UPPER = 6'h10;
    localparam logic [5:0] HSQ_OFS_SOFT_LOWER = 6'h14;
    localparam logic [5:0] HSQ_OFS_SOFT_UPPER_MECH = 6'h18;
    localparam logic [5:0] HSQ_OFS_SOFT_LOWER_MECH = 6'h1c;
    localparam logic [5:0] HSQ_OFS_POSITION = 6'h20;

    // control register fields
    localparam int HSQ_CTRL_START_BIT = 0;
    localparam int HSQ_CTRL_ABORT_BIT = 1;
    localparam int HSQ_CTRL_MODE_LSB = 4;
    localparam int HSQ_CTRL_CFG_LSB = 8;
    // status register fields
    localparam int HSQ_STAT_CODE_LSB = 8;
    localparam int HSQ_STAT_STATE_LSB = 16;

    // reset values
    localparam logic [5:0] HSQ_CFG_RST = 6'h20;
    localparam logic [2:0] HSQ_MODE_RST = 3'h0;
    localparam logic [31:0] HSQ_WORD_RST = 32'h0000_0000;

    // homing modes
    localparam logic [2:0] HSQ_MODE_HOME_SWITCH = 3'h0;
    localparam logic [2:0] HSQ_MODE_LIMIT_SWITCH = 3'h1;
    localparam logic [2:0] HSQ_MODE_HOME_SWITCH_WITH_INDEX = 3'h2;
    localparam logic [2:0] HSQ_MODE_LIMIT_SWITCH_WITH_INDEX = 3'h3;
    localparam logic [2:0] HSQ_MODE_DIRECT = 3'h4;

    // error codes (values arbitrary)
    localparam logic [7:0] HSQ_ERR_NONE = 8'h00;
    localparam logic [7:0] HSQ_PARAMETER_ERROR_CODE = 8'h01;
    localparam logic [7:0] HSQ_ERR_ABORTED = 8'h02;

    typedef enum logic [7:0] {
        HSQ_ST_IDLE = 8'h01,
        HSQ_ST_SEEK = 8'h02,
        HSQ_ST_SEEK_STOP = 8'h04,
        HSQ_ST_CREEP = 8'h08,
        HSQ_ST_ARMED = 8'h10,
        HSQ_ST_LATCH_STOP = 8'h20,
        HSQ_ST_MOVE = 8'h40,
        HSQ_ST_ABORT_STOP = 8'h80
    } hsq_state_e;

    // configuration bits, msb to lsb as stored at HSQ_CTRL_CFG_LSB
    typedef struct packed {
        logic dir_neg;
        logic hard_stop;
        logic ref_en;
        logic home_en;
        logic upper_en;
        logic lower_en;
    } hsq_cfg_s;

    // raw switch and reference inputs
    typedef struct packed {
        logic lower;
        logic upper;
        logic home;
        logic index;
    } hsq_pins_s;

    // command toward the pulse drive
    typedef struct packed {
        logic run;
        logic dir_pos;
        logic creep;
        logic hard_stop;
        logic halt;
        logic move_req;
        logic [31:0] target;
        logic soft_limit_bypass;
    } hsq_drive_cmd_s;

    // answer from the pulse drive
    typedef struct packed {
        logic standstill;
        logic move_done;
        logic [31:0] position;
    } hsq_drive_sts_s;

    // modes that finish on the encoder reference pulse
    function automatic logic hsq_uses_index(input logic [2:0] mode);
        return (mode == HSQ_MODE_HOME_SWITCH_WITH_INDEX) || (mode == HSQ_MODE_LIMIT_SWITCH_WITH_INDEX);
    endfunction : hsq_uses_index

    // modes that search the home switch
    function automatic logic hsq_uses_home(input logic [2:0] mode);
        return (mode == HSQ_MODE_HOME_SWITCH) || (mode == HSQ_MODE_HOME_SWITCH_WITH_INDEX);
    endfunction : hsq_uses_home

endpackage : hsq_pkg

// ==== logic/hsq_sync.sv ====
/*
 * Two-stage synchroniser for asynchronous levels.
 * Assumes slow levels; pulses under one clock may be lost.
 */
module hsq_sync
    import hsq_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    initial begin
        if (WIDTH < 1) begin
            $error("hsq_sync: WIDTH must be at least 1");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } hsq_sync_s;

    hsq_sync_s s;
    hsq_sync_s next_s;

    // first stage feeds only the second stage
    always_comb begin
        next_s.meta = async_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;

endmodule : hsq_sync

// ==== logic/hsq_limit_calc.sv ====
/*
 * Soft-limit calculator: on a strobe, places soft limits around the new home.
 * Assumes same-clock inputs.
 */
module hsq_limit_calc
    import hsq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request
    input wire logic recalc,
    input wire logic [31:0] home_ref,
    input wire logic [31:0] soft_upper,
    input wire logic [31:0] soft_lower,
    // result
    output logic [31:0] upper_mech,
    output logic [31:0] lower_mech
);

    typedef struct packed {
        logic [31:0] upper;
        logic [31:0] lower;
    } hsq_lim_s;

    hsq_lim_s s;
    hsq_lim_s next_s;

    // limits only move on a strobe so they stay stable during motion
    always_comb begin
        next_s = s;
        if (recalc) begin
            next_s.upper = home_ref + soft_upper;
            next_s.lower = home_ref + soft_lower;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign upper_mech = s.upper;
    assign lower_mech = s.lower;

endmodule : hsq_limit_calc

// ==== logic/hsq_axis_homing_sequencer.sv ====
/*
 * Axis homing sequencer: Avalon-MM registers plus search, latch and offset move.
 * Assumes a same-clock pulse drive that stops when run falls and reports standstill.
 */
module hsq_axis_homing_sequencer
    import hsq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // switch and reference pins
    input wire hsq_pins_s pins,
    // pulse drive
    output hsq_drive_cmd_s drive_cmd,
    input wire hsq_drive_sts_s drive_sts
);

    typedef struct packed {
        hsq_state_e state;
        hsq_cfg_s cfg;
        logic [2:0] mode;
        logic [31:0] home_offset;
        logic [31:0] soft_upper;
        logic [31:0] soft_lower;
        logic [31:0] mech_home;
        logic done;
        logic homed;
        logic err;
        logic aborted;
        logic [7:0] err_code;
        logic ack;
        logic [31:0] rdata;
        logic prev_home;
        logic prev_limit;
        logic prev_index;
        logic recalc;
        logic [31:0] home_ref;
        hsq_drive_cmd_s cmd;
    } hsq_main_s;

    hsq_main_s s;
    hsq_main_s next_s;
    hsq_pins_s pins_sync;
    logic [31:0] upper_mech;
    logic [31:0] lower_mech;
    logic bus_wr;
    logic bus_rd;
    logic start_req;
    logic abort_req;
    logic limit_act;
    logic limit_en;
    logic home_fall;
    logic limit_fall;
    logic index_rise;
    logic param_bad;
    logic busy;

    // pins come from the machine, so they are synchronised first
    hsq_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(pins),
        .sync_out(pins_sync)
    );

    // soft limits follow the new home reference
    hsq_limit_calc u_limits (
        .clk(clk),
        .rstn(rstn),
        .recalc(s.recalc),
        .home_ref(s.home_ref),
        .soft_upper(s.soft_upper),
        .soft_lower(s.soft_lower),
        .upper_mech(upper_mech),
        .lower_mech(lower_mech)
    );

    // search-side limit, mirrored for a positive homing direction
    assign limit_act = s.cfg.dir_neg ? pins_sync.lower : pins_sync.upper;
    assign limit_en = s.cfg.dir_neg ? s.cfg.lower_en : s.cfg.upper_en;
    // release and reference edges from synchronised levels
    assign home_fall = s.prev_home & ~pins_sync.home;
    assign limit_fall = s.prev_limit & ~limit_act;
    assign index_rise = pins_sync.index & ~s.prev_index;
    assign busy = (s.state != HSQ_ST_IDLE);

    // one wait cycle per access: the second edge completes it
    assign bus_wr = avs_write & s.ack;
    assign bus_rd = avs_read & ~s.ack;
    assign start_req = bus_wr && (avs_address == HSQ_OFS_CTRL) && avs_writedata[HSQ_CTRL_START_BIT];
    assign abort_req = bus_wr && (avs_address == HSQ_OFS_CTRL) && avs_writedata[HSQ_CTRL_ABORT_BIT];

    // parameter check on the mode about to start
    always_comb begin
        param_bad = 1'b0;
        case (s.mode)
            HSQ_MODE_HOME_SWITCH: param_bad = ~s.cfg.home_en;
            HSQ_MODE_LIMIT_SWITCH: param_bad = ~limit_en;
            HSQ_MODE_HOME_SWITCH_WITH_INDEX: param_bad = ~s.cfg.home_en | ~s.cfg.ref_en;
            HSQ_MODE_LIMIT_SWITCH_WITH_INDEX: param_bad = ~limit_en | ~s.cfg.ref_en;
            HSQ_MODE_DIRECT: param_bad = 1'b0;
            default: param_bad = 1'b1;
        endcase
    end

    // register file, sequencer and drive command
    always_comb begin
        next_s = s;
        next_s.ack = (avs_read | avs_write) & ~s.ack;
        next_s.recalc = 1'b0;
        next_s.cmd.move_req = 1'b0;
        next_s.cmd.halt = 1'b0;
        next_s.prev_home = pins_sync.home;
        next_s.prev_limit = limit_act;
        next_s.prev_index = pins_sync.index;

        // configuration writes are locked out while a sequence runs
        if (bus_wr && !busy) begin
            case (avs_address)
                HSQ_OFS_CTRL: begin
                    next_s.mode = avs_writedata[HSQ_CTRL_MODE_LSB +: 3];
                    next_s.cfg = avs_writedata[HSQ_CTRL_CFG_LSB +: 6];
                end
                HSQ_OFS_HOME_OFFSET: next_s.home_offset = avs_writedata;
                HSQ_OFS_SOFT_UPPER: next_s.soft_upper = avs_writedata;
                HSQ_OFS_SOFT_LOWER: next_s.soft_lower = avs_writedata;
                default: next_s.rdata = s.rdata;
            endcase
        end

        // read data registered in the wait cycle
        if (bus_rd) begin
            case (avs_address)
                HSQ_OFS_CTRL: begin
                    next_s.rdata = HSQ_WORD_RST;
                    next_s.rdata[HSQ_CTRL_MODE_LSB +: 3] = s.mode;
                    next_s.rdata[HSQ_CTRL_CFG_LSB +: 6] = s.cfg;
                end
                HSQ_OFS_STATUS: begin
                    next_s.rdata = {27'h0, s.aborted, s.err, s.homed, s.done, busy};
                    next_s.rdata[HSQ_STAT_CODE_LSB +: 8] = s.err_code;
                    next_s.rdata[HSQ_STAT_STATE_LSB +: 8] = s.state;
                end
                HSQ_OFS_HOME_OFFSET: next_s.rdata = s.home_offset;
                HSQ_OFS_MECH_HOME: next_s.rdata = s.mech_home;
                HSQ_OFS_SOFT_UPPER: next_s.rdata = s.soft_upper;
                HSQ_OFS_SOFT_LOWER: next_s.rdata = s.soft_lower;
                HSQ_OFS_SOFT_UPPER_MECH: next_s.rdata = upper_mech;
                HSQ_OFS_SOFT_LOWER_MECH: next_s.rdata = lower_mech;
                HSQ_OFS_POSITION: next_s.rdata = drive_sts.position;
                default: next_s.rdata = HSQ_WORD_RST;
            endcase
        end

        case (s.state)
            HSQ_ST_IDLE: begin
                next_s.cmd.soft_limit_bypass = 1'b0;
                if (start_req) begin
                    next_s.done = 1'b0;
                    next_s.err = 1'b0;
                    next_s.aborted = 1'b0;
                    next_s.err_code = HSQ_ERR_NONE;
                    next_s.homed = 1'b0;
                    next_s.mech_home = HSQ_WORD_RST;
                    if (param_bad) begin
                        next_s.err = 1'b1;
                        next_s.err_code = HSQ_PARAMETER_ERROR_CODE;
                    end else if (s.mode == HSQ_MODE_DIRECT) begin
                        // static homing: current position becomes home
                        next_s.mech_home = drive_sts.position;
                        next_s.home_ref = drive_sts.position;
                        next_s.recalc = 1'b1;
                        next_s.homed = 1'b1;
                        next_s.done = 1'b1;
                    end else begin
                        next_s.cmd.soft_limit_bypass = 1'b1;
                        next_s.cmd.run = 1'b1;
                        next_s.cmd.hard_stop = 1'b0;
                        if (limit_act || (hsq_uses_home(s.mode) && pins_sync.home)) begin
                            // already on a switch: creep away at once
                            next_s.cmd.dir_pos = s.cfg.dir_neg;
                            next_s.cmd.creep = 1'b1;
                            next_s.state = HSQ_ST_CREEP;
                        end else begin
                            next_s.cmd.dir_pos = ~s.cfg.dir_neg;
                            next_s.cmd.creep = 1'b0;
                            next_s.state = HSQ_ST_SEEK;
                        end
                    end
                end
            end
            HSQ_ST_SEEK: begin
                // a disabled limit is never a stop condition
                if (limit_en && limit_act) begin
                    next_s.cmd.run = 1'b0;
                    next_s.cmd.hard_stop = s.cfg.hard_stop;
                    next_s.state = HSQ_ST_SEEK_STOP;
                end else if (hsq_uses_home(s.mode) && pins_sync.home) begin
                    next_s.cmd.run = 1'b0;
                    next_s.cmd.hard_stop = 1'b0;
                    next_s.state = HSQ_ST_SEEK_STOP;
                end
            end
            HSQ_ST_SEEK_STOP: begin
                if (drive_sts.standstill) begin
                    next_s.cmd.run = 1'b1;
                    next_s.cmd.hard_stop = 1'b0;
                    next_s.cmd.dir_pos = s.cfg.dir_neg;
                    next_s.cmd.creep = 1'b1;
                    next_s.state = HSQ_ST_CREEP;
                end
            end
            HSQ_ST_CREEP: begin
                if (hsq_uses_home(s.mode) ? home_fall : limit_fall) begin
                    if (hsq_uses_index(s.mode)) begin
                        next_s.state = HSQ_ST_ARMED;
                    end else begin
                        next_s.mech_home = drive_sts.position;
                        next_s.cmd.run = 1'b0;
                        next_s.state = HSQ_ST_LATCH_STOP;
                    end
                end
            end
            HSQ_ST_ARMED: begin
                if (index_rise) begin
                    next_s.mech_home = drive_sts.position;
                    next_s.cmd.run = 1'b0;
                    next_s.state = HSQ_ST_LATCH_STOP;
                end
            end
            HSQ_ST_LATCH_STOP: begin
                if (drive_sts.standstill) begin
                    next_s.cmd.target = s.mech_home + s.home_offset;
                    next_s.home_ref = s.mech_home + s.home_offset;
                    next_s.recalc = 1'b1;
                    next_s.cmd.move_req = 1'b1;
                    next_s.state = HSQ_ST_MOVE;
                end
            end
            HSQ_ST_MOVE: begin
                if (drive_sts.move_done) begin
                    next_s.homed = 1'b1;
                    next_s.done = 1'b1;
                    next_s.cmd.soft_limit_bypass = 1'b0;
                    next_s.state = HSQ_ST_IDLE;
                end
            end
            HSQ_ST_ABORT_STOP: begin
                if (drive_sts.standstill) begin
                    next_s.cmd.soft_limit_bypass = 1'b0;
                    next_s.state = HSQ_ST_IDLE;
                end
            end
            default: begin
                next_s.cmd.run = 1'b0;
                next_s.state = HSQ_ST_IDLE;
            end
        endcase

        // abort overrides any step in progress
        if (abort_req && busy && (s.state != HSQ_ST_ABORT_STOP)) begin
            next_s.cmd.run = 1'b0;
            next_s.cmd.hard_stop = 1'b0;
            next_s.cmd.halt = 1'b1;
            next_s.cmd.move_req = 1'b0;
            next_s.homed = 1'b0;
            next_s.mech_home = HSQ_WORD_RST;
            next_s.aborted = 1'b1;
            next_s.err_code = HSQ_ERR_ABORTED;
            next_s.state = HSQ_ST_ABORT_STOP;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.state <= HSQ_ST_IDLE;
            s.cfg <= HSQ_CFG_RST;
            s.mode <= HSQ_MODE_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs
    assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
    assign avs_readdata = s.rdata;
    assign drive_cmd = s.cmd;

endmodule : hsq_axis_homing_sequencer

// ==== verification/hsq_axis_sva.sv ====
/* port checker for the axis homing sequencer.
   assumes it is bound onto hsq_axis_homing_sequencer, one clock domain. */
module hsq_axis_sva
    import hsq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // pins and drive
    input wire hsq_pins_s pins,
    input wire hsq_drive_cmd_s drive_cmd,
    input wire hsq_drive_sts_s drive_sts
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // every access is answered one cycle after it is seen
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_bypass_run: assert property (drive_cmd.run |-> drive_cmd.soft_limit_bypass)
        else $error("soft limits enforced while homing");
    a_seek_dir: assert property (drive_cmd.run && !drive_cmd.creep |-> !drive_cmd.dir_pos)
        else $error("fast seek not negative");
    a_creep_dir: assert property (drive_cmd.run && drive_cmd.creep |-> drive_cmd.dir_pos)
        else $error("creep not positive");
    // sync plus the registered run command gives a few cycles of slack
    a_lower_stop: assert property ($rose(pins.lower) && drive_cmd.run && !drive_cmd.dir_pos
        |-> ##[1:6] !drive_cmd.run)
        else $error("seek ran past lower limit");
    a_restart_wait: assert property (!drive_sts.standstill && !drive_cmd.run |=> !drive_cmd.run)
        else $error("restart before standstill");
    a_move_stopped: assert property (drive_cmd.move_req |-> !drive_cmd.run && drive_sts.standstill)
        else $error("offset move while axis moving");
    a_halt_stops: assert property (drive_cmd.halt |-> !drive_cmd.run && !drive_cmd.move_req)
        else $error("abort left motion running");

    c_creep: cover property (drive_cmd.run && drive_cmd.creep);
    c_move: cover property (drive_cmd.move_req);
    c_halt: cover property (drive_cmd.halt);
endmodule : hsq_axis_sva

bind hsq_axis_homing_sequencer hsq_axis_sva i_hsq_axis_sva (.clk(clk), .rstn(rstn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .pins(pins), .drive_cmd(drive_cmd),
    .drive_sts(drive_sts));

// ==== verification/hsq_axis_model.sv ====
/* pulse drive and axis model with switch cams and index mark.
   assumes the sequencer clock; positions in pulses. */
module hsq_axis_model
    import hsq_pkg::*;
#(
    parameter int LOWER_EDGE = -32'sh12c,
    parameter int HOME_LO = 32'sh64,
    parameter int HOME_HI = 32'shc8,
    parameter int UPPER_EDGE = 32'sh1388
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // position preset
    input wire logic load,
    input wire logic [31:0] load_pos,
    // sequencer side
    input wire hsq_drive_cmd_s drive_cmd,
    output hsq_drive_sts_s drive_sts,
    output hsq_pins_s pins
);
    logic signed [31:0] pos, sp, goal, mag;
    logic [1:0] decel;
    logic moving, done;

    // cams from most negative to most positive: lower, home, upper
    assign pins.lower = pos <= LOWER_EDGE;
    assign pins.home = pos >= HOME_LO && pos <= HOME_HI;
    assign pins.upper = pos >= UPPER_EDGE;
    // index four pulses wide so the two-stage sync cannot miss it
    assign pins.index = pos[5:0] < 6'h04;
    assign mag = drive_cmd.creep ? 32'sh1 : 32'sh4;
    assign drive_sts = '{standstill: !drive_cmd.run && decel == 2'h0 && !moving, move_done: done, position: pos};

    // motion: velocity moves, coast on stop unless hard stop or halt, absolute move
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pos <= '0;
            sp <= '0;
            goal <= '0;
            decel <= 2'h0;
            moving <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                pos <= load_pos;
            end else if (drive_cmd.halt) begin
                decel <= 2'h0;
                moving <= 1'b0;
            end else if (drive_cmd.run) begin
                sp <= drive_cmd.dir_pos ? mag : -mag;
                pos <= pos + (drive_cmd.dir_pos ? mag : -mag);
                decel <= 2'h3;
            end else if (decel != 2'h0) begin
                decel <= drive_cmd.hard_stop ? 2'h0 : decel - 2'h1;
                pos <= drive_cmd.hard_stop ? pos : pos + sp;
            end else if (drive_cmd.move_req) begin
                moving <= 1'b1;
                goal <= drive_cmd.target;
            end else if (moving) begin
                moving <= pos != goal;
                done <= pos == goal;
                pos <= pos == goal ? pos : pos + (goal > pos ? 32'sh1 : -32'sh1);
            end
        end
    end
endmodule : hsq_axis_model

// ==== verification/tb.sv ====
/* self-checking bench for the homing sequencer over its register bus.
   assumes the axis model and the bound checker; seed fixed at 4. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hsq_pkg::*;
    localparam logic [2:0] BAD_M [5] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h5};
    localparam logic [5:0] BAD_C [5] = '{6'h21, 6'h2c, 6'h25, 6'h29, 6'h3d};
    logic clk, rstn, avs_read, avs_write, avs_waitrequest, load;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, load_pos, rng, rd;
    hsq_pins_s pins;
    hsq_drive_cmd_s drive_cmd;
    hsq_drive_sts_s drive_sts;
    int err_total, comparisons;

    hsq_axis_homing_sequencer i_hsq_axis_homing_sequencer (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pins(pins), .drive_cmd(drive_cmd), .drive_sts(drive_sts));
    hsq_axis_model i_hsq_axis_model (.clk(clk), .rstn(rstn), .load(load), .load_pos(load_pos),
        .drive_cmd(drive_cmd), .drive_sts(drive_sts), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // start bit with mode and configuration fields
    function automatic logic [31:0] ctrl_word(input logic [2:0] m, input logic [5:0] c);
        return {18'h0, c, 1'h0, m, 4'h1};
    endfunction : ctrl_word

    // a start checks the mode and enables already stored, so store them first
    task automatic go(input logic [2:0] m, input logic [5:0] c);
        bus(1'b1, HSQ_OFS_CTRL, ctrl_word(m, c) & ~32'h1);
        bus(1'b1, HSQ_OFS_CTRL, ctrl_word(m, c));
    endtask : go

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one bus access held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_total++;
            tally_and_finish();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, HSQ_OFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            err_total++;
            tally_and_finish();
        end
    endtask : wait_idle

    task automatic preset(input logic [31:0] p);
        load_pos <= p;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
    endtask : preset

    // one homing run from a random spot near base; home must land near edge
    task automatic run_home(input logic [2:0] m, input logic signed [31:0] base, input logic signed [31:0] edge_p);
        logic [31:0] ofs;
        logic signed [31:0] mech;
        rng = xs(rng);
        ofs = {24'h0, rng[7:0] | 8'h01}; // positive offset against the lower side
        preset(base + {26'h0, rng[13:8]}); // start 0 to 63 pulses above base
        bus(1'b1, HSQ_OFS_HOME_OFFSET, ofs);
        go(m, {2'b10, 4'hd} | {1'b0, rng[16], 4'h0});
        wait_idle();
        chk("status", 32'h6, rd & 32'hff1f);
        bus(1'b0, HSQ_OFS_MECH_HOME, 32'h0);
        mech = rd;
        chk("mech_window", 32'h1, {31'h0, mech >= edge_p && mech <= edge_p + 8});
        bus(1'b0, HSQ_OFS_POSITION, 32'h0);
        chk("final_pos", mech + ofs, rd);
        chk("standstill", 32'h1, {31'h0, drive_sts.standstill});
        $display("test homing mode %0d done", m);
    endtask : run_home

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        rstn = 1'b0;
        avs_address = 6'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        load = 1'b0;
        load_pos = 32'h0;
        rng = 32'h4;
        err_total = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(1'b0, HSQ_OFS_CTRL, 32'h0);
        chk("ctrl_reset", 32'h2000, rd);
        bus(1'b0, 6'h3c, 32'h0);
        chk("unmapped", 32'h0, rd);
        // disabled inputs and an undefined mode are refused at once
        for (int i = 0; i < 5; i++) begin
            go(BAD_M[i], BAD_C[i]);
            bus(1'b0, HSQ_OFS_STATUS, 32'h0);
            chk("param_status", 32'h0108, rd & 32'hff09);
        end
        $display("test refusals done");
        run_home(3'h0, 32'sh190, 32'shc9);
        run_home(3'h0, -32'shc8, 32'shc9);
        run_home(3'h0, 32'sh78, 32'shc9);
        run_home(3'h0, -32'sh190, 32'shc9);
        run_home(3'h1, 32'sh190, -32'sh12b);
        run_home(3'h1, -32'sh190, -32'sh12b);
        run_home(3'h2, 32'sh190, 32'sh100);
        run_home(3'h2, -32'shc8, 32'sh100);
        run_home(3'h3, 32'sh190, -32'sh100);
        // a new start drops the old home, then an abort mid-search
        preset(32'h0000_0190);
        go(3'h0, 6'h2d);
        bus(1'b0, HSQ_OFS_STATUS, 32'h0);
        chk("start_homed", 32'h0, {31'h0, rd[2]});
        bus(1'b0, HSQ_OFS_MECH_HOME, 32'h0);
        chk("start_mech", 32'h0, rd);
        bus(1'b1, HSQ_OFS_CTRL, 32'h0000_2d02);
        wait_idle();
        chk("abort_status", 32'h0210, rd & 32'hff14);
        bus(1'b0, HSQ_OFS_MECH_HOME, 32'h0);
        chk("abort_mech", 32'h0, rd);
        $display("test abort done");
        tally_and_finish();
    end
endmodule : tb
